// File: design/rcsa_map.svh
// offsets, field positions, reset values and timing figures of the calendar block
`ifndef RCSA_MAP_SVH
`define RCSA_MAP_SVH
`define RCSA_DEV_ADDR 7'h6f
`define RCSA_ADDR_MAX 8'h3f
`define RCSA_SR_ADDR 6'h3f
`define RCSA_SEC_AL0 3'h0
`define RCSA_SEC_AL1 3'h1
`define RCSA_SEC_CTL 3'h2
`define RCSA_SEC_RTC 3'h6
`define RCSA_SEC_SR 3'h7
`define RCSA_CTL_END 6'h14
`define RCSA_NV_BYTES 20
`define RCSA_REPEAT_IDX 5'h11
`define RCSA_AL_EN 7
`define RCSA_HR_MIL 7
`define RCSA_HR_PM 5
`define RCSA_SR_WEL 1
`define RCSA_SR_REGISTER_WRITE_ENABLE_LATCH 2
`define RCSA_Y2K_RST 8'h20
`define RCSA_TIME_RST 64'h2000_0000_0000_0000
`define RCSA_XTAL_HZ 32768
`define RCSA_WB_CTRL 8'h00
`define RCSA_WB_STAT 8'h04
`define RCSA_WB_TIME 8'h08
`endif

// File: design/rcsa_pkg.sv
// types shared by the calendar block
package rcsa_pkg;
  // byte i of the packed value is the counter at offset 0x30 + i
  typedef struct packed {
    logic [7:0] y2k;
    logic [7:0] dow;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rcsa_time_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } rcsa_wb_req_t;

  typedef enum logic [2:0] {ST_IDLE, ST_SLV, ST_AHI, ST_ALO, ST_WR, ST_RD, ST_IGN} rcsa_state_t;
endpackage

// File: design/rcsa_sync.sv
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module rcsa_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// File: design/rcsa_calendar.sv
// next-second value of the bcd time and calendar counters
`timescale 1ns/1ps
`include "rcsa_map.svh"
module rcsa_calendar (
  input rcsa_pkg::rcsa_time_t cur,
  output rcsa_pkg::rcsa_time_t nxt
);
  import rcsa_pkg::*;

  logic [7:0] hourVal;
  logic [7:0] hourInc;
  logic [7:0] lastDay;
  logic leap;
  logic pmNew;
  logic dayRoll;

  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  always_comb
  begin
    // divisible by four in bcd; 1900 is the one century year excluded, 2000 stays leap
    leap = (cur.year[4] ? (cur.year[1:0] == 2'b10) : (cur.year[1:0] == 2'b00))
      && !(cur.year == 8'h00 && cur.y2k == 8'h19);
    case (cur.month)
      8'h02: lastDay = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: lastDay = 8'h30;
      default: lastDay = 8'h31;
    endcase
  end

  always_comb
  begin
    nxt = cur;
    dayRoll = 1'b0;
    pmNew = cur.hour[`RCSA_HR_PM];
    hourVal = cur.hour[`RCSA_HR_MIL] ? {2'b00, cur.hour[5:0]} : {3'b000, cur.hour[4:0]};
    hourInc = bcdInc(hourVal);
    nxt.sec = bcdInc(cur.sec);
    if (cur.sec == 8'h59)
    begin
      nxt.sec = 8'h00;
      nxt.min = bcdInc(cur.min);
      if (cur.min == 8'h59)
      begin
        nxt.min = 8'h00;
        if (cur.hour[`RCSA_HR_MIL])
        begin
          // 24-hour format
          dayRoll = (hourVal == 8'h23);
          nxt.hour = {1'b1, 1'b0, (dayRoll ? 6'h00 : hourInc[5:0])};
        end
        else
        begin
          // 12-hour format with pm flag
          if (hourVal == 8'h12)
          begin
            hourInc = 8'h01;
          end
          else if (hourVal == 8'h11)
          begin
            pmNew = ~cur.hour[`RCSA_HR_PM];
            dayRoll = cur.hour[`RCSA_HR_PM];
          end
          nxt.hour = {2'b00, pmNew, hourInc[4:0]};
        end
      end
    end
    if (dayRoll)
    begin
      nxt.dow = (cur.dow[2:0] == 3'h6) ? 8'h00 : {5'h00, cur.dow[2:0] + 3'h1};
      nxt.date = bcdInc(cur.date);
      if (cur.date == lastDay)
      begin
        nxt.date = 8'h01;
        nxt.month = bcdInc(cur.month);
        if (cur.month == 8'h12)
        begin
          nxt.month = 8'h01;
          nxt.year = bcdInc(cur.year);
          if (cur.year == 8'h99)
          begin
            nxt.year = 8'h00;
            nxt.y2k = (cur.y2k == 8'h19) ? 8'h20 : cur.y2k;
          end
        end
      end
    end
  end
endmodule

// File: design/rcsa_top.sv
// real-time clock with calendar, alarms and two-wire register access
`timescale 1ns/1ps
`include "rcsa_map.svh"
module rcsa_top #(
  parameter int TICK_DIV = `RCSA_XTAL_HZ
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic xtalIn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input rcsa_pkg::rcsa_wb_req_t wbReq,
  output logic wbAck,
  output logic [31:0] wbDatO
);
  import rcsa_pkg::*;

  logic [2:0] syncS;
  logic xtalS;
  logic sclS;
  logic sdaS;
  logic xtalP_q;
  logic sclP_q;
  logic sdaP_q;
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  logic xtalRise;

  rcsa_state_t st_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic acking_q;
  logic rdMode_q;
  logic lastByte_q;
  logic [5:0] ptr_q;
  logic sdaOeN_q;
  logic sdaOut_q;

  logic [7:0] nv_q [0:`RCSA_NV_BYTES-1];
  logic [7:0] shadow_q [0:7];
  logic [7:0] dirty_q;
  rcsa_time_t time_q;
  rcsa_time_t snap_q;
  rcsa_time_t timeNext;
  logic halt_q;
  logic wel_q;
  logic register_write_enable_latch_q;
  logic [1:0] alFlag_q;
  logic [1:0] arm_q;
  logic [1:0] matchP_q;
  logic [1:0] match;
  logic [1:0] alSet;
  logic [15:0] div_q;
  logic tick;

  logic accept;
  logic byteDone;
  logic ackDone;
  logic loadTx;
  logic snapNow;
  logic secRtc;
  logic secValid;
  logic commitOk;
  logic rtcCommit;
  logic srWrite;
  logic srRead;
  logic [5:0] nextPtr;
  logic [7:0] rdByte;
  logic [7:0] statusByte;

  logic wbReqOk;
  logic pwrLoss;
  logic wbAck_q;
  logic [31:0] wbDat_q;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  // scl and sda idle high, so no false edge follows reset
  rcsa_sync #(
    .W(3),
    .INIT(3'h6)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({sdaIn, sclIn, xtalIn}),
    .q(syncS)
  );

  assign xtalS = syncS[0];
  assign sclS = syncS[1];
  assign sdaS = syncS[2];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      xtalP_q <= 1'b0;
      sclP_q <= 1'b1;
      sdaP_q <= 1'b1;
    end
    else
    begin
      xtalP_q <= xtalS;
      sclP_q <= sclS;
      sdaP_q <= sdaS;
    end
  end

  assign sclRise = sclS & ~sclP_q;
  assign sclFall = ~sclS & sclP_q;
  assign startEv = sclS & sclP_q & sdaP_q & ~sdaS;
  assign stopEv = sclS & sclP_q & ~sdaP_q & sdaS;
  assign xtalRise = xtalS & ~xtalP_q;

  ////////////////////////////////////////////////////////////////////////////////
  // byte decode and register addressing

  assign statusByte = {1'b0, alFlag_q[1], alFlag_q[0], 2'b00, register_write_enable_latch_q, wel_q, halt_q};
  assign secRtc = (ptr_q[5:3] == `RCSA_SEC_RTC);
  assign secValid = (ptr_q < `RCSA_CTL_END) | secRtc;
  assign byteDone = sclFall & (bitCnt_q == 4'd7);
  assign ackDone = sclFall & (bitCnt_q == 4'd8);

  always_comb
  begin
    case (st_q)
      ST_SLV: accept = (shift_q[7:1] == `RCSA_DEV_ADDR);
      ST_AHI: accept = (shift_q == 8'h00);
      ST_ALO: accept = (shift_q <= `RCSA_ADDR_MAX);
      ST_WR: accept = ~lastByte_q;
      default: accept = 1'b0;
    endcase
  end

  always_comb
  begin
    // sequential access stays inside one section
    case (ptr_q[5:3])
      `RCSA_SEC_SR: nextPtr = ptr_q;
      `RCSA_SEC_CTL: nextPtr = {ptr_q[5:2], ptr_q[1:0] + 2'h1};
      default: nextPtr = {ptr_q[5:3], ptr_q[2:0] + 3'h1};
    endcase
  end

  always_comb
  begin
    if (ptr_q < `RCSA_CTL_END)
    begin
      rdByte = nv_q[ptr_q[4:0]];
    end
    else if (secRtc)
    begin
      // first byte of a read leaves with the capture made at the same edge
      rdByte = snapNow ? time_q[{ptr_q[2:0], 3'b000} +: 8]
        : snap_q[{ptr_q[2:0], 3'b000} +: 8];
    end
    else if (ptr_q == `RCSA_SR_ADDR)
    begin
      rdByte = statusByte;
    end
    else
    begin
      rdByte = 8'h00;
    end
  end

  assign snapNow = ackDone & (st_q == ST_SLV) & acking_q & rdMode_q;
  assign loadTx = ackDone & (((st_q == ST_SLV) & acking_q & rdMode_q)
    | ((st_q == ST_RD) & ~shift_q[0] & ~lastByte_q));
  assign srRead = loadTx & (ptr_q == `RCSA_SR_ADDR);
  assign srWrite = byteDone & (st_q == ST_WR) & accept & (ptr_q == `RCSA_SR_ADDR);
  // stop must follow whole acknowledged bytes; repeated start never commits
  assign commitOk = stopEv & (st_q == ST_WR) & (bitCnt_q == 4'd0) & register_write_enable_latch_q
    & (|dirty_q) & secValid;
  assign rtcCommit = commitOk & secRtc;

  ////////////////////////////////////////////////////////////////////////////////
  // two-wire slave protocol

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_q <= 8'h00;
    end
    else if (sclRise)
    begin
      shift_q <= {shift_q[6:0], sdaS};
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= ST_IDLE;
      bitCnt_q <= 4'd0;
      acking_q <= 1'b0;
      rdMode_q <= 1'b0;
      lastByte_q <= 1'b0;
      ptr_q <= 6'h00;
      tx_q <= 8'h00;
      sdaOeN_q <= 1'b1;
    end
    else if (startEv)
    begin
      st_q <= ST_SLV;
      // the start's own scl fall wraps the count to zero
      bitCnt_q <= 4'hf;
      lastByte_q <= 1'b0;
      sdaOeN_q <= 1'b1;
    end
    else if (stopEv)
    begin
      st_q <= ST_IDLE;
      sdaOeN_q <= 1'b1;
    end
    else if (sclFall)
    begin
      case (st_q)
        ST_IDLE, ST_IGN:
        begin
          sdaOeN_q <= 1'b1;
        end
        ST_RD:
        begin
          if (bitCnt_q == 4'd8)
          begin
            bitCnt_q <= 4'd0;
            if (loadTx)
            begin
              tx_q <= rdByte;
              sdaOeN_q <= rdByte[7];
              ptr_q <= nextPtr;
              lastByte_q <= (ptr_q == `RCSA_SR_ADDR);
            end
            else
            begin
              st_q <= ST_IGN;
              sdaOeN_q <= 1'b1;
            end
          end
          else if (bitCnt_q == 4'd7)
          begin
            bitCnt_q <= 4'd8;
            sdaOeN_q <= 1'b1;
          end
          else
          begin
            bitCnt_q <= bitCnt_q + 4'd1;
            tx_q <= {tx_q[6:0], 1'b0};
            sdaOeN_q <= tx_q[6];
          end
        end
        default:
        begin
          if (bitCnt_q == 4'd7)
          begin
            bitCnt_q <= 4'd8;
            acking_q <= accept;
            sdaOeN_q <= ~accept;
            if (st_q == ST_SLV)
            begin
              rdMode_q <= shift_q[0];
            end
            if (st_q == ST_ALO && accept)
            begin
              ptr_q <= shift_q[5:0];
            end
            if (st_q == ST_WR && ptr_q == `RCSA_SR_ADDR)
            begin
              lastByte_q <= 1'b1;
            end
          end
          else if (bitCnt_q == 4'd8)
          begin
            bitCnt_q <= 4'd0;
            sdaOeN_q <= 1'b1;
            if (!acking_q)
            begin
              st_q <= ST_IGN;
            end
            else
            begin
              case (st_q)
                ST_SLV:
                begin
                  if (rdMode_q)
                  begin
                    st_q <= ST_RD;
                    tx_q <= rdByte;
                    sdaOeN_q <= rdByte[7];
                    ptr_q <= nextPtr;
                    lastByte_q <= (ptr_q == `RCSA_SR_ADDR);
                  end
                  else
                  begin
                    st_q <= ST_AHI;
                  end
                end
                ST_AHI: st_q <= ST_ALO;
                ST_ALO: st_q <= ST_WR;
                ST_WR: ptr_q <= nextPtr;
                default: st_q <= ST_IGN;
              endcase
            end
          end
          else
          begin
            bitCnt_q <= bitCnt_q + 4'd1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read snapshot, write shadow buffer and write enable latch

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      snap_q <= `RCSA_TIME_RST;
    end
    else if (snapNow)
    begin
      snap_q <= time_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dirty_q <= 8'h00;
      for (int i = 0; i < 8; i++)
      begin
        shadow_q[i] <= 8'h00;
      end
    end
    else if (startEv)
    begin
      dirty_q <= 8'h00;
    end
    else if (ackDone && st_q == ST_ALO && acking_q)
    begin
      dirty_q <= 8'h00;
      for (int i = 0; i < 8; i++)
      begin
        if (secRtc)
        begin
          shadow_q[i] <= time_q[{3'(i), 3'b000} +: 8];
        end
        else if ({ptr_q[4:3], 3'(i)} < 5'(`RCSA_NV_BYTES))
        begin
          shadow_q[i] <= nv_q[{ptr_q[4:3], 3'(i)}];
        end
        else
        begin
          shadow_q[i] <= 8'h00;
        end
      end
    end
    else if (byteDone && st_q == ST_WR && accept && ptr_q != `RCSA_SR_ADDR)
    begin
      shadow_q[ptr_q[2:0]] <= shift_q;
      dirty_q[ptr_q[2:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wel_q <= 1'b0;
      register_write_enable_latch_q <= 1'b0;
    end
    else if (srWrite)
    begin
      wel_q <= shift_q[`RCSA_SR_WEL];
      register_write_enable_latch_q <= shift_q[`RCSA_SR_WEL] & shift_q[`RCSA_SR_REGISTER_WRITE_ENABLE_LATCH] & wel_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // nonvolatile alarm and control bytes

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < `RCSA_NV_BYTES; i++)
      begin
        nv_q[i] <= (i == 7 || i == 15) ? `RCSA_Y2K_RST : 8'h00;
      end
    end
    else if (commitOk && !secRtc)
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (dirty_q[i])
        begin
          nv_q[{ptr_q[4:3], 3'(i)}] <= shadow_q[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timebase and live counters

  rcsa_calendar u_cal (
    .cur(time_q),
    .nxt(timeNext)
  );

  assign tick = xtalRise & ~halt_q & ~rtcCommit & (div_q == 16'(TICK_DIV - 1));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_q <= 16'h0000;
    end
    else if (halt_q || rtcCommit)
    begin
      div_q <= 16'h0000;
    end
    else if (xtalRise)
    begin
      div_q <= (div_q == 16'(TICK_DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      time_q <= `RCSA_TIME_RST;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (rtcCommit && dirty_q[i])
        begin
          time_q[{3'(i), 3'b000} +: 8] <= shadow_q[i];
        end
        else if (tick)
        begin
          time_q[{3'(i), 3'b000} +: 8] <= timeNext[{3'(i), 3'b000} +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      halt_q <= 1'b1;
    end
    else if (pwrLoss)
    begin
      halt_q <= 1'b1;
    end
    else if (rtcCommit)
    begin
      halt_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // alarm match against live time

  always_comb
  begin
    for (int a = 0; a < 2; a++)
    begin
      logic [4:0] b;
      logic any;
      logic hit;
      b = 5'(a * 8);
      any = 1'b0;
      hit = 1'b1;
      // live counters, never the read snapshot
      if (nv_q[b][`RCSA_AL_EN])
      begin
        any = 1'b1;
        hit = hit & (nv_q[b][6:0] == time_q.sec[6:0]);
      end
      if (nv_q[b + 5'd1][`RCSA_AL_EN])
      begin
        any = 1'b1;
        hit = hit & (nv_q[b + 5'd1][6:0] == time_q.min[6:0]);
      end
      if (nv_q[b + 5'd2][`RCSA_AL_EN])
      begin
        any = 1'b1;
        hit = hit & (nv_q[b + 5'd2][5:0] == time_q.hour[5:0]);
      end
      if (nv_q[b + 5'd3][`RCSA_AL_EN])
      begin
        any = 1'b1;
        hit = hit & (nv_q[b + 5'd3][5:0] == time_q.date[5:0]);
      end
      if (nv_q[b + 5'd4][`RCSA_AL_EN])
      begin
        any = 1'b1;
        hit = hit & (nv_q[b + 5'd4][4:0] == time_q.month[4:0]);
      end
      if (nv_q[b + 5'd6][`RCSA_AL_EN])
      begin
        any = 1'b1;
        hit = hit & (nv_q[b + 5'd6][2:0] == time_q.dow[2:0]);
      end
      match[a] = any & hit;
    end
  end

  assign alSet = match & ~matchP_q & arm_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      matchP_q <= 2'b00;
      alFlag_q <= 2'b00;
      arm_q <= 2'b11;
    end
    else
    begin
      matchP_q <= match;
      // a new match beats the clear-on-read of the status byte
      alFlag_q <= (alFlag_q & ~{2{srRead}}) | alSet;
      for (int a = 0; a < 2; a++)
      begin
        if (commitOk && ptr_q[5:3] == 3'(a))
        begin
          arm_q[a] <= 1'b1;
        end
        else if (alSet[a] && !nv_q[`RCSA_REPEAT_IDX][6 + a])
        begin
          arm_q[a] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone slave for supervision

  assign wbReqOk = wbReq.cyc & wbReq.stb & ~wbAck_q;
  assign pwrLoss = wbReqOk & wbReq.we & (wbReq.adr == `RCSA_WB_CTRL) & wbReq.sel[0] & wbReq.dat[0];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wbAck_q <= 1'b0;
      wbDat_q <= 32'h0000_0000;
    end
    else
    begin
      wbAck_q <= wbReqOk;
      if (wbReqOk && !wbReq.we)
      begin
        case (wbReq.adr)
          `RCSA_WB_STAT: wbDat_q <= {22'h00_0000, arm_q, statusByte};
          `RCSA_WB_TIME: wbDat_q <= time_q[31:0];
          default: wbDat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sdaOut_q <= 1'b0;
    end
    else
    begin
      sdaOut_q <= 1'b0;
    end
  end

  assign sdaOut = sdaOut_q;
  assign sdaOeN = sdaOeN_q;
  assign wbAck = wbAck_q;
  assign wbDatO = wbDat_q;
endmodule

// File: sim/rcsa_props.sv
// assertions on the calendar block ports
`timescale 1ns/1ps
module rcsa_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input rcsa_pkg::rcsa_wb_req_t wbReq,
  input wire logic wbAck,
  input wire logic [31:0] wbDatO,
  input wire logic sdaOut,
  input wire logic sdaOeN
);
  import rcsa_pkg::*;
  logic req;
  logic rd;
  assign req = wbReq.cyc && wbReq.stb && !wbAck;
  assign rd = req && !wbReq.we;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  a_ack_next: assert property (req |=> wbAck) else $error("ack late");
  a_ack_once: assert property (wbAck |=> !wbAck) else $error("ack long");
  a_ack_cause: assert property (wbAck |-> $past(req)) else $error("stray ack");
  a_sda_low: assert property (sdaOut == 1'b0) else $error("sda high");
  a_sda_turn: assert property ($changed(sdaOeN) |-> !sclIn) else $error("sda turn");
  a_gap_zero:
    assert property (rd && wbReq.adr != 8'h04 && wbReq.adr != 8'h08 |=> wbDatO == 32'h0)
    else $error("gap data");
  a_stat_fixed:
    assert property (rd && wbReq.adr == 8'h04 |=> wbDatO[31:10] == 22'h0 && wbDatO[4:3] == 2'h0)
    else $error("stat bits");
  a_sec_bcd:
    assert property (rd && wbReq.adr == 8'h08 |=> wbDatO[7:4] < 4'h6 && wbDatO[3:0] < 4'ha)
    else $error("sec bcd");
  c_time_rd: cover property (rd && wbReq.adr == 8'h08);
  c_stat_rd: cover property (rd && wbReq.adr == 8'h04);
  c_dev_pull: cover property ($fell(sdaOeN));
endmodule
bind rcsa_top rcsa_props u_rcsa_props (.clk(clk), .sys_rst(sys_rst), .sclIn(sclIn),
  .wbReq(wbReq), .wbAck(wbAck), .wbDatO(wbDatO), .sdaOut(sdaOut), .sdaOeN(sdaOeN));

// File: sim/rcsa_hm.sv
// serial host master model on an open-drain data line
`timescale 1ns/1ps
module rcsa_hm (
  input wire logic clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaOeN
);
  initial
  begin
    scl = 1'b1;
    sdaOeN = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    w(2);
    sdaOeN <= 1'b1;
    w(2);
    scl <= 1'b1;
    w(4);
    sdaOeN <= 1'b0;
    w(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    w(2);
    sdaOeN <= 1'b0;
    w(2);
    scl <= 1'b1;
    w(4);
    sdaOeN <= 1'b1;
    w(4);
  endtask
  // data moves mid low phase, sampled at end of high phase
  task automatic bitx(input logic b, output logic r);
    w(2);
    sdaOeN <= b;
    w(2);
    scl <= 1'b1;
    w(4);
    r = sdaLine;
    scl <= 1'b0;
  endtask
  task automatic wrB(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rdB(output logic [7:0] b, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(!ack, r);
  endtask
endmodule

// File: sim/rcsa_top_tb.sv
// self-checking bench of the calendar block
`timescale 1ns/1ps
`define CK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module rcsa_top_tb;
  import rcsa_pkg::*;
  logic clk, sys_rst, xtalIn, sclIn, sdaOut, sdaOeN, hostOeN, wbAck, k;
  logic [31:0] wbDatO, q, t;
  logic [7:0] y, h, m;
  logic [7:0] rb[$];
  rcsa_wb_req_t wbReq;
  wire sdaLine = sdaOeN & hostOeN;
  int mismatches, tests_run;
  int cycles = 0;
  rcsa_top #(.TICK_DIV(4)) u_rcsa_top (.clk(clk), .sys_rst(sys_rst), .xtalIn(xtalIn),
    .sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .wbReq(wbReq),
    .wbAck(wbAck), .wbDatO(wbDatO));
  rcsa_hm u_rcsa_hm (.clk(clk), .sdaLine(sdaLine), .scl(sclIn), .sdaOeN(hostOeN));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always
  begin
    repeat (4) @(posedge clk);
    xtalIn <= ~xtalIn;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wb(input logic [7:0] a, input logic wr = 1'b0, input logic [31:0] d = 32'h0);
    wbReq <= '{1'b1, 1'b1, wr, 4'hf, a, d};
    @(posedge clk);
    while (wbAck !== 1'b1)
    begin
      @(posedge clk);
    end
    q = wbDatO;
    wbReq <= '0;
    @(posedge clk);
  endtask
  task automatic adr(input logic [7:0] a);
    u_rcsa_hm.start();
    u_rcsa_hm.wrB(8'hde, k);
    u_rcsa_hm.wrB(8'h00, k);
    u_rcsa_hm.wrB(a, k);
  endtask
  task automatic sw(input logic [7:0] a, input logic rs);
    adr(a);
    foreach (rb[i]) u_rcsa_hm.wrB(rb[i], k);
    if (rs)
      u_rcsa_hm.start();
    u_rcsa_hm.stop();
  endtask
  task automatic sr(input logic [7:0] a, input int n);
    logic [7:0] v;
    rb = {};
    if (!a[7])
      adr(a);
    u_rcsa_hm.start();
    u_rcsa_hm.wrB(8'hdf, k);
    for (int i = 0; i < n; i++)
    begin
      u_rcsa_hm.rdB(v, i < n - 1);
      rb.push_back(v);
    end
    u_rcsa_hm.stop();
  endtask
  task automatic en();
    rb = {8'h02};
    sw(8'h3f, 1'b0);
    rb = {8'h06};
    sw(8'h3f, 1'b0);
  endtask
  function automatic logic [15:0] roll(input logic [7:0] hr, input logic [7:0] yr);
    if (hr == 8'h11)
      return 16'h2832;
    return ((yr[7:4] * 10 + yr[3:0]) % 4 == 0) ? 16'h2980 : 16'h0180;
  endfunction
  initial
  begin
    void'($urandom(32'hc492_4377));
    sys_rst = 1'b1;
    wbReq = '0;
    xtalIn = 1'b0;
    mismatches = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    wb(8'h04);
    `CK("stat", 32'h0000_0301, q)
    wb(8'h20);
    `CK("gap", 32'h0, q)
    repeat (100) @(posedge clk);
    wb(8'h08);
    `CK("halt", 32'h0, q)
    for (int i = 0; i < 4; i++)
    begin
      y = i == 0 ? 8'h99 : i == 1 ? 8'h96 : {4'($urandom_range(9)), 4'($urandom_range(9))};
      h = i == 3 ? 8'h11 : 8'ha3;
      en();
      rb = {8'h59, 8'h59, h, 8'h28, 8'h02, y};
      sw(8'h30, 1'b0);
      repeat (4) @(posedge clk);
      wb(8'h08);
      `CK("load", {8'h28, h, 16'h5959}, q)
      repeat (40) @(posedge clk);
      wb(8'h08);
      `CK("roll", {roll(h, y), 16'h0}, q)
    end
    m = {4'($urandom_range(4)), 4'($urandom_range(9))};
    en();
    rb = {m};
    sw(8'h31, 1'b0);
    wb(8'h08);
    `CK("single", {16'h2832, m}, q[31:8])
    `CK("run", 1'b1, q[7:0] != 8'h0)
    t = q;
    en();
    rb = {8'h05};
    sw(8'h32, 1'b1);
    wb(8'h08);
    `CK("abort", t[31:16], q[31:16])
    u_rcsa_hm.start();
    u_rcsa_hm.wrB(8'hd0, k);
    u_rcsa_hm.stop();
    `CK("slave", 1'b0, k)
    adr(8'h40);
    u_rcsa_hm.stop();
    `CK("range", 1'b0, k)
    sr(8'h32, 2);
    `CK("read", 16'h3228, {rb[0], rb[1]})
    sr(8'h80, 1);
    `CK("next", 8'h02, rb[0])
    en();
    rb = {8'h85};
    sw(8'h00, 1'b0);
    q = '0;
    for (int i = 0; i < 40 && q[5] !== 1'b1; i++)
    begin
      repeat (60) @(posedge clk);
      wb(8'h04);
    end
    `CK("alarm", 1'b1, q[5])
    sr(8'h3f, 1);
    `CK("flag", 1'b1, rb[0][5])
    wb(8'h04);
    `CK("clear", 1'b0, q[5])
    wb(8'h00, 1'b1, 32'h1);
    wb(8'h08);
    t = q;
    repeat (80) @(posedge clk);
    wb(8'h08);
    `CK("stopped", t, q)
    stop_test();
  end
endmodule
